// >>> hdl/osc_pkg.sv
// Shared constants and types for the oscillator select and tuning block
package osc_pkg;
  // Register addresses on the plain register port
  localparam logic [11:0] OSC_TRIM_ADDR = 12'hf9b; // Tuning register
  localparam logic [11:0] OSC_CTRL_ADDR = 12'hfd3; // Control register
  localparam int OSC_ADDR_W = 12; // Register port address width
  localparam int OSC_DATA_W = 8; // Register port data width

  // Tuning register field positions
  localparam int TRIM_LSB = 0; // Frequency trim, bits 5:0
  localparam int TRIM_W = 6; // Trim width
  localparam int MULT_BIT = 6; // Multiplier enable
  localparam int LFSRC_BIT = 7; // Low-frequency source select

  // Control register field positions
  localparam int SCS_LSB = 0; // System clock select, bits 1:0
  localparam int UNIMP_BIT = 2; // Unimplemented, reads one
  localparam int STS_BIT = 3; // Start-up timer done
  localparam int IFS_LSB = 4; // Internal frequency select, bits 6:4
  localparam int IDLE_BIT = 7; // Idle on sleep

  // Reset values
  localparam logic [7:0] TRIM_RST = 8'h00; // Tuning register
  localparam logic [2:0] IFS_RST = 3'h6; // 4 MHz setting
  localparam logic [1:0] SCS_RST = 2'h0; // Primary source
  localparam logic IDLE_RST = 1'b0; // Full sleep

  // System clock select codes
  localparam logic [1:0] SCS_PRIMARY = 2'h0; // Primary clock source
  localparam logic [1:0] SCS_SECONDARY = 2'h1; // Timer1 oscillator
  localparam logic [1:0] SCS_RESERVED = 2'h2; // Reserved
  localparam logic [1:0] SCS_INTERNAL = 2'h3; // Postscaled internal clock

  // Internal frequency select codes
  localparam logic [2:0] IFS_8MHZ = 3'h7; // Undivided fast oscillator
  localparam logic [2:0] IFS_31KHZ = 3'h0; // Low-frequency source

  // Oscillator configuration codes that route primary to the postscaler
  localparam logic [2:0] OSC_CFG_INT_A = 3'h0; // Internal oscillator mode
  localparam logic [2:0] OSC_CFG_INT_B = 3'h1; // Internal oscillator mode
  // Secondary oscillator configuration code for digital input mode
  localparam logic [1:0] SEC_CFG_DIGITAL = 2'h2;

  // Switch pause: cycles of the old and the new source
  localparam logic [1:0] OLD_CYCLES = 2'h2; // Old source cycles
  localparam logic [1:0] NEW_CYCLES = 2'h3; // New source cycles before resync
  localparam int NUM_SRC = 4; // Source vector width, indexed by select code

  // Clock switch states
  typedef enum logic [3:0] {
    SW_RUN = 4'b0001, // Output follows current source
    SW_DRAIN = 4'b0010, // Counting old source cycles
    SW_WAIT = 4'b0100, // Counting new source cycles
    SW_SYNC = 4'b1000 // Waiting for new source low
  } osc_sw_state_t;
endpackage

// >>> hdl/osc_sw_if.sv
// Carrier between the control logic and the glitch-free clock switch
interface osc_sw_if;
  import osc_pkg::*;
  logic [NUM_SRC-1:0] src_lvl; // Sampled level of each candidate source
  logic [1:0] target; // Requested source, never the reserved code
  logic [1:0] cur; // Source currently on the output
  logic busy; // Switch pause in progress
  logic clk_out; // Gated system clock
  modport ctrl (output src_lvl, output target, input cur, input busy, input clk_out);
  modport sw (input src_lvl, input target, output cur, output busy, output clk_out);
endinterface

// >>> hdl/osc_glitch_switch.sv
// Glitch-free switch between the sampled clock sources
module osc_glitch_switch
  import osc_pkg::*;
(
  input wire logic clk, // Block clock
  input wire logic rst_n, // Synchronised reset, active low
  osc_sw_if.sw sw // Source levels in, gated clock out
);
  osc_sw_state_t state_reg; // Switch state
  logic [NUM_SRC-1:0] prev_reg; // Previous source levels, for edges
  logic [1:0] cur_reg; // Source on the output
  logic [1:0] nxt_reg; // Source being switched to
  logic [1:0] cnt_reg; // Edge counter
  logic out_reg; // Registered output clock
  logic old_fall; // Falling edge on the old source
  logic new_rise; // Rising edge on the new source

  assign old_fall = prev_reg[cur_reg] & ~sw.src_lvl[cur_reg];
  assign new_rise = ~prev_reg[nxt_reg] & sw.src_lvl[nxt_reg];

  // Edge history of every source
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= sw.src_lvl;
    end
  end

  // pause two old falling edges plus three new rising edges, then new source low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SW_RUN;
      cur_reg <= SCS_RST;
      nxt_reg <= SCS_RST;
      cnt_reg <= 2'h0;
    end else begin
      case (state_reg)
        SW_RUN: begin
          // A new target latches; later changes wait for the next switch
          if (sw.target != cur_reg) begin
            nxt_reg <= sw.target;
            cnt_reg <= 2'h0;
            state_reg <= SW_DRAIN;
          end
        end
        SW_DRAIN: begin
          if (old_fall) begin
            if (cnt_reg == OLD_CYCLES - 2'h1) begin
              cnt_reg <= 2'h0;
              state_reg <= SW_WAIT;
            end else begin
              cnt_reg <= cnt_reg + 2'h1;
            end
          end
        end
        SW_WAIT: begin
          if (new_rise) begin
            if (cnt_reg == NEW_CYCLES - 2'h1) begin
              state_reg <= SW_SYNC;
            end else begin
              cnt_reg <= cnt_reg + 2'h1;
            end
          end
        end
        SW_SYNC: begin
          // Resume only from a low level so the first pulse is whole
          if (!sw.src_lvl[nxt_reg]) begin
            cur_reg <= nxt_reg;
            state_reg <= SW_RUN;
          end
        end
        default: begin
          state_reg <= SW_RUN;
        end
      endcase
    end
  end

  // output follows the old source until its second falling edge, then held low to the end of the pause
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= 1'b0;
    end else if (state_reg == SW_RUN || state_reg == SW_DRAIN) begin
      // Old source keeps running until its second falling edge
      out_reg <= sw.src_lvl[cur_reg] & ~(state_reg == SW_DRAIN && old_fall && cnt_reg == OLD_CYCLES - 2'h1);
    end else begin
      out_reg <= 1'b0;
    end
  end

  assign sw.cur = cur_reg;
  assign sw.busy = (state_reg != SW_RUN);
  assign sw.clk_out = out_reg;
endmodule

// >>> hdl/osc_select_top.sv
// Oscillator tuning, internal postscaler and system clock selection
module osc_select_top
  import osc_pkg::*;
(
  input wire logic REF_CLK_IN, // Block clock, 40 MHz
  input wire logic RESETN_IN, // Asynchronous reset, active low
  input wire logic [OSC_ADDR_W-1:0] ADDR_IN, // Register address
  input wire logic [OSC_DATA_W-1:0] WDATA_IN, // Register write data
  input wire logic WR_IN, // Write strobe
  input wire logic RD_IN, // Read strobe
  output logic [OSC_DATA_W-1:0] RDATA_OUT, // Read data, cycle after strobe
  input wire logic CFG_MULTIPLIER_ENABLE_IN, // Configuration multiplier enable
  input wire logic SECONDARY_OSC_ENABLE_IN, // Timer1 oscillator enable
  input wire logic [1:0] SECONDARY_OSC_CONFIG_IN, // Secondary oscillator mode
  input wire logic [2:0] OSC_CONFIG_SELECT_IN, // Oscillator configuration
  input wire logic TWO_SPEED_IN, // Two-speed start-up enabled
  input wire logic PRIMARY_READY_IN, // Start-up timer expired, primary runs
  input wire logic FAST_INTERNAL_OSC_IN, // Fast internal oscillator level
  input wire logic SLOW_INTERNAL_OSC_IN, // Slow internal oscillator level
  input wire logic SECONDARY_OSC_IN, // Timer1 oscillator level
  input wire logic CPU_DIVIDER_IN, // CPU divider output level
  input wire logic SLEEP_IN, // Sleep instruction pulse
  output logic SYS_CLK_OUT, // Gated system clock
  output logic SWITCH_BUSY_OUT, // Clock switch in progress
  output logic [1:0] ACTIVE_SOURCE_OUT, // Source on the system clock
  output logic MULTIPLIER_ON_OUT, // Frequency multiplier running
  output logic [TRIM_W-1:0] FREQ_TRIM_OUT, // Raw signed trim code
  output logic [TRIM_W-1:0] TRIM_LEVEL_OUT, // Monotonic trim level
  output logic INTERNAL_CLK_OUT, // Postscaled internal clock
  output logic IDLE_ENTER_OUT, // Pulse: enter idle mode
  output logic SLEEP_ENTER_OUT // Pulse: enter full sleep
);
  // Reset release
  logic rst_meta_reg; // First synchroniser stage
  logic rst_n_reg; // Synchronised reset, active low

  // Tuning register fields
  logic low_freq_source_select; // Low-frequency source select
  logic multiplier_enable; // Multiplier enable
  logic [TRIM_W-1:0] freq_trim; // Signed frequency trim
  logic [7:0] osc_trim_reg; // Tuning register image

  // Control register fields
  logic idle_on_sleep; // Idle on sleep
  logic [2:0] internal_freq_select; // Internal frequency select
  logic startup_timer_done; // Start-up status
  logic [1:0] system_clock_select; // System clock select
  logic strap_done_reg; // Start-up strap already taken
  logic [7:0] osc_control_reg; // Control register image

  // Postscaler
  logic fast_prev_reg; // Previous fast oscillator level
  logic [7:0] pscale_cnt_reg; // Ripple count of fast edges
  logic int_clk; // Selected postscaler tap
  logic primary_clk; // Primary source after configuration mux

  // Bus decode
  logic wr_trim; // Write hits tuning register
  logic wr_ctrl; // Write hits control register
  logic [1:0] scs_wr; // Select field after the secondary guard
  logic [OSC_DATA_W-1:0] rdata_reg; // Registered read data

  // Sleep outputs
  logic idle_pulse_reg; // Idle entry pulse
  logic sleep_pulse_reg; // Sleep entry pulse

  osc_sw_if sw_if (); // Carrier to the clock switch

  // Offset binary turns the signed trim into a rising level
  function automatic logic [TRIM_W-1:0] trim_level(input logic [TRIM_W-1:0] code);
    trim_level = {~code[TRIM_W-1], code[TRIM_W-2:0]};
  endfunction

  // Only legal select codes may be handed to the switch
  function automatic logic [1:0] legal_target(input logic [1:0] scs, input logic [1:0] keep);
    legal_target = (scs == SCS_RESERVED) ? keep : scs;
  endfunction

  // Reset is applied at once but released through two flops
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // Address decode; the two strobes never coincide
  assign wr_trim = WR_IN && (ADDR_IN == OSC_TRIM_ADDR);
  assign wr_ctrl = WR_IN && (ADDR_IN == OSC_CTRL_ADDR);

  always_comb begin
    scs_wr = WDATA_IN[SCS_LSB +: 2];
    if (scs_wr == SCS_SECONDARY && !SECONDARY_OSC_ENABLE_IN && SECONDARY_OSC_CONFIG_IN != SEC_CFG_DIGITAL) begin
      // Keep the previous select; the rest of the byte still lands
      scs_wr = system_clock_select;
    end
  end

  // Tuning register, all bits writable
  always_ff @(posedge REF_CLK_IN or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      low_freq_source_select <= TRIM_RST[LFSRC_BIT];
      multiplier_enable <= TRIM_RST[MULT_BIT];
      freq_trim <= TRIM_RST[TRIM_LSB +: TRIM_W];
    end else if (wr_trim) begin
      low_freq_source_select <= WDATA_IN[LFSRC_BIT];
      multiplier_enable <= WDATA_IN[MULT_BIT];
      freq_trim <= WDATA_IN[TRIM_LSB +: TRIM_W];
    end
  end

  // frequency field resets to 4 MHz
  always_ff @(posedge REF_CLK_IN or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      idle_on_sleep <= IDLE_RST;
      internal_freq_select <= IFS_RST;
      system_clock_select <= SCS_RST;
    end else if (wr_ctrl) begin
      idle_on_sleep <= WDATA_IN[IDLE_BIT];
      internal_freq_select <= WDATA_IN[IFS_LSB +: 3];
      // a changed select starts a switch, except the reserved code, which is stored but not switched to
      system_clock_select <= scs_wr;
    end
  end

  // strap picks the start-up bit after release
  always_ff @(posedge REF_CLK_IN or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      strap_done_reg <= 1'b0;
      startup_timer_done <= 1'b0;
    end else if (!strap_done_reg) begin
      // Strap is a level, so it is caught by the clock, not the reset
      strap_done_reg <= 1'b1;
      startup_timer_done <= ~TWO_SPEED_IN;
    end else begin
      // status tracks the primary ready level
      startup_timer_done <= PRIMARY_READY_IN;
    end
  end

  // Register images as software reads them
  assign osc_trim_reg = {low_freq_source_select, multiplier_enable, freq_trim};
  // bit two is a constant one
  assign osc_control_reg = {idle_on_sleep, internal_freq_select, startup_timer_done, 1'b1, system_clock_select};

  // Read data stand for one cycle only; unmapped reads return zero
  always_ff @(posedge REF_CLK_IN or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rdata_reg <= 8'h00;
    end else if (RD_IN && ADDR_IN == OSC_TRIM_ADDR) begin
      rdata_reg <= osc_trim_reg;
    end else if (RD_IN && ADDR_IN == OSC_CTRL_ADDR) begin
      rdata_reg <= osc_control_reg;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // Count rising edges of the fast oscillator for the divided taps
  always_ff @(posedge REF_CLK_IN or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      fast_prev_reg <= 1'b0;
      pscale_cnt_reg <= 8'h00;
    end else begin
      fast_prev_reg <= FAST_INTERNAL_OSC_IN;
      if (FAST_INTERNAL_OSC_IN && !fast_prev_reg) begin
        pscale_cnt_reg <= pscale_cnt_reg + 8'h01;
      end
    end
  end

  always_comb begin
    case (internal_freq_select)
      IFS_8MHZ: int_clk = FAST_INTERNAL_OSC_IN; // Undivided
      3'h6: int_clk = pscale_cnt_reg[0]; // Divide by 2
      3'h5: int_clk = pscale_cnt_reg[1]; // Divide by 4
      3'h4: int_clk = pscale_cnt_reg[2]; // Divide by 8
      3'h3: int_clk = pscale_cnt_reg[3]; // Divide by 16
      3'h2: int_clk = pscale_cnt_reg[4]; // Divide by 32
      3'h1: int_clk = pscale_cnt_reg[5]; // Divide by 64
      IFS_31KHZ: begin
        // fast divided by 256 or slow
        int_clk = low_freq_source_select ? pscale_cnt_reg[7] : SLOW_INTERNAL_OSC_IN;
      end
      default: int_clk = FAST_INTERNAL_OSC_IN;
    endcase
  end

  assign primary_clk = (OSC_CONFIG_SELECT_IN == OSC_CFG_INT_A || OSC_CONFIG_SELECT_IN == OSC_CFG_INT_B)
    ? int_clk : CPU_DIVIDER_IN;

  // source vector indexed by select code
  assign sw_if.src_lvl = {int_clk, 1'b0, SECONDARY_OSC_IN, primary_clk};
  assign sw_if.target = legal_target(system_clock_select, sw_if.cur);

  osc_glitch_switch u_switch (
    .clk(REF_CLK_IN),
    .rst_n(rst_n_reg),
    .sw(sw_if.sw)
  );

  // sleep instruction enters idle or sleep
  always_ff @(posedge REF_CLK_IN or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      idle_pulse_reg <= 1'b0;
      sleep_pulse_reg <= 1'b0;
    end else begin
      idle_pulse_reg <= SLEEP_IN & idle_on_sleep;
      sleep_pulse_reg <= SLEEP_IN & ~idle_on_sleep;
    end
  end

  // software keeps 8 or 4 MHz here
  assign MULTIPLIER_ON_OUT = multiplier_enable | CFG_MULTIPLIER_ENABLE_IN;
  // signed trim mapped to monotonic level
  assign TRIM_LEVEL_OUT = trim_level(freq_trim);
  assign FREQ_TRIM_OUT = freq_trim;
  assign INTERNAL_CLK_OUT = int_clk;
  assign RDATA_OUT = rdata_reg;
  assign SYS_CLK_OUT = sw_if.clk_out;
  assign SWITCH_BUSY_OUT = sw_if.busy;
  assign ACTIVE_SOURCE_OUT = sw_if.cur;
  assign IDLE_ENTER_OUT = idle_pulse_reg;
  assign SLEEP_ENTER_OUT = sleep_pulse_reg;
endmodule

// >>> testbench/osc_select_chk.sv
// Port-level checker for the oscillator select block, bound to its top module
module osc_select_chk
  import osc_pkg::*;
(
  input wire logic REF_CLK_IN, // Block clock
  input wire logic RESETN_IN, // Reset, active low
  input wire logic RD_IN, // Read strobe
  input wire logic [OSC_DATA_W-1:0] RDATA_OUT, // Read data
  input wire logic CFG_MULTIPLIER_ENABLE_IN, // Config multiplier enable
  input wire logic SLEEP_IN, // Sleep pulse
  input wire logic SYS_CLK_OUT, // Gated system clock
  input wire logic SWITCH_BUSY_OUT, // Switch pause
  input wire logic [1:0] ACTIVE_SOURCE_OUT, // Source on the clock
  input wire logic MULTIPLIER_ON_OUT, // Multiplier running
  input wire logic [TRIM_W-1:0] FREQ_TRIM_OUT, // Raw trim
  input wire logic [TRIM_W-1:0] TRIM_LEVEL_OUT, // Monotonic trim level
  input wire logic IDLE_ENTER_OUT, // Idle pulse
  input wire logic SLEEP_ENTER_OUT // Sleep pulse
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  a_read_data_once: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
    else $error("read data outside its cycle");
  a_cfg_keeps_mult: assert property (CFG_MULTIPLIER_ENABLE_IN |-> MULTIPLIER_ON_OUT)
    else $error("multiplier off with config enable");
  a_trim_level_map: assert property (TRIM_LEVEL_OUT == {~FREQ_TRIM_OUT[5], FREQ_TRIM_OUT[4:0]})
    else $error("trim level not monotonic map");
  a_sleep_one_mode: assert property (SLEEP_IN |=> IDLE_ENTER_OUT != SLEEP_ENTER_OUT)
    else $error("sleep did not pick one mode");
  a_no_stray_mode: assert property (!$past(SLEEP_IN) |-> !IDLE_ENTER_OUT && !SLEEP_ENTER_OUT)
    else $error("mode pulse without sleep");
  a_reserved_never: assert property (ACTIVE_SOURCE_OUT != 2'h2)
    else $error("reserved source became active");
  a_source_at_end: assert property ($changed(ACTIVE_SOURCE_OUT) |-> $fell(SWITCH_BUSY_OUT))
    else $error("source changed outside end of pause");
  a_pause_bounded: assert property ($rose(SWITCH_BUSY_OUT) |-> ##[1:300] !SWITCH_BUSY_OUT)
    else $error("switch pause too long");
  a_no_runt_high: assert property ($rose(SYS_CLK_OUT) |=> SYS_CLK_OUT)
    else $error("runt high pulse on system clock");
  a_no_runt_low: assert property ($fell(SYS_CLK_OUT) |=> !SYS_CLK_OUT)
    else $error("runt low pulse on system clock");
endmodule

bind osc_select_top osc_select_chk osc_select_chk_i (
  .REF_CLK_IN(REF_CLK_IN), .RESETN_IN(RESETN_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
  .CFG_MULTIPLIER_ENABLE_IN(CFG_MULTIPLIER_ENABLE_IN), .SLEEP_IN(SLEEP_IN), .SYS_CLK_OUT(SYS_CLK_OUT),
  .SWITCH_BUSY_OUT(SWITCH_BUSY_OUT), .ACTIVE_SOURCE_OUT(ACTIVE_SOURCE_OUT),
  .MULTIPLIER_ON_OUT(MULTIPLIER_ON_OUT), .FREQ_TRIM_OUT(FREQ_TRIM_OUT), .TRIM_LEVEL_OUT(TRIM_LEVEL_OUT),
  .IDLE_ENTER_OUT(IDLE_ENTER_OUT), .SLEEP_ENTER_OUT(SLEEP_ENTER_OUT));

// >>> testbench/tb_top.sv
// Self-checking bench for the oscillator select block
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("Error at %0t ns: got %0h expected %0h", $time, (g), (e)); end end
module tb_top
  import osc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, cfg_mult = 1'b0, sec_en = 1'b0;
  logic tw_speed = 1'b1, prim_rdy = 1'b0, sleep = 1'b0, sys_clk, busy, mult_on, int_clk, idle_e, sleep_e;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00, rdata, d;
  logic [1:0] sec_cfg = 2'h0, active;
  logic [2:0] osc_cfg = 3'h2;
  logic [5:0] trim, level;
  logic [4:0] src_cnt = 5'h00; // Source clock generator
  int failures = 0, samples_checked = 0, n, len;
  // Trim codes and their expected levels
  logic [5:0] n_trim [3] = '{6'h1f, 6'h00, 6'h20};
  logic [5:0] n_lvl [3] = '{6'h3f, 6'h20, 6'h00};

  always #12.5 ref_clk = ~ref_clk;
  // Sources hold each level at least two cycles, as the sampler needs
  always @(posedge ref_clk) src_cnt <= src_cnt + 5'h01;

  osc_select_top osc_select_top_i (.REF_CLK_IN(ref_clk), .RESETN_IN(resetn), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .CFG_MULTIPLIER_ENABLE_IN(cfg_mult),
    .SECONDARY_OSC_ENABLE_IN(sec_en), .SECONDARY_OSC_CONFIG_IN(sec_cfg), .OSC_CONFIG_SELECT_IN(osc_cfg),
    .TWO_SPEED_IN(tw_speed), .PRIMARY_READY_IN(prim_rdy), .FAST_INTERNAL_OSC_IN(src_cnt[1]),
    .SLOW_INTERNAL_OSC_IN(src_cnt[3]), .SECONDARY_OSC_IN(src_cnt[4]), .CPU_DIVIDER_IN(src_cnt[2]),
    .SLEEP_IN(sleep), .SYS_CLK_OUT(sys_clk), .SWITCH_BUSY_OUT(busy), .ACTIVE_SOURCE_OUT(active),
    .MULTIPLIER_ON_OUT(mult_on), .FREQ_TRIM_OUT(trim), .TRIM_LEVEL_OUT(level),
    .INTERNAL_CLK_OUT(int_clk), .IDLE_ENTER_OUT(idle_e), .SLEEP_ENTER_OUT(sleep_e));

  // Verdict and end of run
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One-cycle write strobe
  task automatic reg_wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  // One-cycle read strobe; data only in the following cycle
  task automatic reg_rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    v = rdata;
  endtask

  // Bounded wait for the pause flag; a hang ends the run
  task automatic wait_busy(input logic lvl, output int cyc);
    cyc = 0;
    while (busy !== lvl) begin
      @(negedge ref_clk);
      cyc++;
      if (cyc > 400) begin
        failures++;
        $display("Error at %0t ns: switch wait ran out", $time);
        test_done();
      end
    end
  endtask

  // Rising edges of one clock output over a window
  task automatic count_rises(input logic pick, input int ncyc, output int cnt);
    logic prev;
    logic v;
    @(negedge ref_clk);
    prev = pick ? int_clk : sys_clk;
    cnt = 0;
    repeat (ncyc) begin
      @(negedge ref_clk);
      v = pick ? int_clk : sys_clk;
      if (v === 1'b1 && prev === 1'b0) cnt++;
      prev = v;
    end
  endtask

  // Switch to a new select code and wait out the pause
  task automatic do_switch(input logic [7:0] v);
    reg_wr(OSC_CTRL_ADDR, v);
    wait_busy(1'b1, n);
    wait_busy(1'b0, len);
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reg_rd(OSC_TRIM_ADDR, d); `CHK(d, 8'h00) // trim resets centre
    reg_rd(OSC_CTRL_ADDR, d); `CHK(d, 8'h64) // control reset
    reg_rd(12'h000, d); `CHK(d, 8'h00)
    @(posedge ref_clk);
    prim_rdy <= 1'b1;
    reg_rd(OSC_CTRL_ADDR, d); `CHK(d, 8'h6c) // start-up bit follows
    reg_wr(OSC_CTRL_ADDR, 8'h00);
    reg_rd(OSC_CTRL_ADDR, d); `CHK(d, 8'h0c) // bit two stays one
    reg_wr(OSC_CTRL_ADDR, 8'h60); // 4 MHz while the multiplier runs
    // Trim extremes and centre
    foreach (n_trim[i]) begin
      reg_wr(OSC_TRIM_ADDR, {2'h0, n_trim[i]});
      @(negedge ref_clk);
      `CHK(trim, n_trim[i]) // raw trim
      `CHK(level, n_lvl[i]) // ordered level
    end
    reg_wr(OSC_TRIM_ADDR, 8'h40);
    @(negedge ref_clk);
    `CHK(mult_on, 1'b1) // bit turns multiplier on
    reg_wr(OSC_TRIM_ADDR, 8'h00);
    @(negedge ref_clk);
    `CHK(mult_on, 1'b0) // bit turns it off
    @(posedge ref_clk);
    cfg_mult <= 1'b1;
    @(negedge ref_clk);
    `CHK(mult_on, 1'b1) // config keeps it on
    @(posedge ref_clk);
    // multiplier off before the slower taps
    cfg_mult <= 1'b0;
    @(negedge ref_clk);
    `CHK(mult_on, 1'b0) // both enables clear
    // Every postscaler tap over a window of 512 cycles, the divide by 256 over 2048
    for (int c = 7; c >= 0; c--) begin
      reg_wr(OSC_CTRL_ADDR, {1'b0, 3'(c), 4'h0});
      count_rises(1'b1, 512, n);
      `CHK(n, (c == 0) ? 32 : (128 >> (7 - c))) // tap rate
    end
    reg_wr(OSC_TRIM_ADDR, 8'h80);
    count_rises(1'b1, 2048, n); `CHK(n, 2) // fast source over 256
    // Sleep picks idle or full sleep
    for (int k = 0; k < 2; k++) begin
      reg_wr(OSC_CTRL_ADDR, {1'(k), 7'h70});
      @(posedge ref_clk);
      sleep <= 1'b1;
      @(posedge ref_clk);
      sleep <= 1'b0;
      @(negedge ref_clk);
      `CHK({idle_e, sleep_e}, {1'(k), ~1'(k)}) // mode pulse
    end
    // Divider primary to undivided internal clock
    do_switch(8'h73);
    `CHK((len >= 12) && (len <= 44), 1'b1) // pause length
    `CHK(active, SCS_INTERNAL) // new source active
    count_rises(1'b0, 512, n); `CHK(n, 128) // follows new source
    reg_wr(OSC_CTRL_ADDR, 8'h71);
    repeat (6) @(negedge ref_clk);
    `CHK({busy, active}, {1'b0, SCS_INTERNAL}) // request ignored
    reg_rd(OSC_CTRL_ADDR, d); `CHK(d, 8'h7f) // select kept
    @(posedge ref_clk);
    sec_cfg <= SEC_CFG_DIGITAL;
    do_switch(8'h71); // secondary source already running
    `CHK(active, SCS_SECONDARY) // digital mode allows
    count_rises(1'b0, 512, n); `CHK(n, 16) // secondary on clock
    reg_wr(OSC_CTRL_ADDR, 8'h72);
    repeat (6) @(negedge ref_clk);
    `CHK({busy, active}, {1'b0, SCS_SECONDARY}) // reserved no switch
    reg_rd(OSC_CTRL_ADDR, d); `CHK(d, 8'h7e) // reserved stored
    @(posedge ref_clk);
    sec_en <= 1'b1;
    osc_cfg <= OSC_CFG_INT_A;
    do_switch(8'h70);
    `CHK(active, SCS_PRIMARY) // primary select
    count_rises(1'b0, 512, n); `CHK(n, 128) // postscaler as primary
    // Strap changes only while both candidate levels are low, so no runt
    @(posedge ref_clk);
    repeat (8) if (src_cnt[2:0] != 3'h0) @(posedge ref_clk);
    osc_cfg <= 3'h2;
    count_rises(1'b0, 512, n); `CHK(n, 64) // divider as primary
    // Second reset with two-speed off; status read at the edge after the strap
    @(posedge ref_clk);
    tw_speed <= 1'b0;
    prim_rdy <= 1'b0;
    resetn <= 1'b0;
    repeat (6) @(posedge ref_clk);
    // Release aligned to the divider so the first output pulse is whole
    repeat (8) if (src_cnt[2:0] != 3'h0) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reg_rd(OSC_CTRL_ADDR, d); `CHK(d, 8'h6c) // status resets to one
    reg_rd(OSC_CTRL_ADDR, d); `CHK(d, 8'h64) // then follows ready
    test_done();
  end
endmodule
